// ### inc/sdp_defs.svh
// constants for the dual processing-element datapath
// Overview of operation
// [RULE_01] The primary element is always on and runs every computational instruction.
// [RULE_02] The second element runs only while the enable bit of the first mode register is set.
// [RULE_03] With both enabled, one instruction runs in both elements on their own operands.
// [RULE_04] In dual mode each load or store moves two values, one per element.
// [RULE_05] ALU, multiplier and shifter each finish in one cycle and may all work together.
// [RULE_06] A multifunction instruction does an ALU and a multiplier operation in parallel.
// [RULE_07] Units handle 32-bit fixed point and the sign of single and 40-bit float words.
// [RULE_08] Each register file has 32 registers, 16 primary and 16 secondary, many ports.
// [RULE_09] Register file, address registers and multiplier result all have secondary copies.
// [RULE_10] Primary sets are active after reset; a secondary set needs its mode bit set.
// [RULE_11] Four universal registers give set, clear, toggle, test and xor bit operations.
// [RULE_12] The exchange register moves data between the 64-bit buses and the 40-bit file.
// [RULE_13] The two memory buses together carry four 32-bit values each cycle.
// [RULE_14] Four operands, two over each bus, can be taken in one cycle.
// [RULE_15] A disabled second element keeps its state and transfers stay single-valued.
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH
`define SDP_DW 40
`define SDP_MW 64
`define SDP_BW 64
`define SDP_WW 32
`define SDP_RF_REGS 32
`define SDP_DAG_REGS 32
`define SDP_UBR_N 4
`define SDP_FXH 39
`define SDP_FXL 8
`define SDP_SIGN 39
`define SDP_SHH 12
`define SDP_M1_RF_SEC 0
`define SDP_M1_DAG_SEC 1
`define SDP_M1_MRF_SEC 2
`define SDP_M1_PE2_EN 3
`define SDP_TGT_FIRST_MODE_CONTROL_REGISTER 3'h4
`define SDP_FIRST_MODE_CONTROL_REGISTER_RST 32'h0000_0000
`endif

// ### inc/sdp_pkg.sv
// types and shared helpers of the dual processing-element datapath
`include "sdp_defs.svh"
package sdp_pkg;
    typedef enum logic [2:0] {
        ALU_NOP = 3'h0, ALU_ADD = 3'h1, ALU_SUB = 3'h2, ALU_AND = 3'h3,
        ALU_OR = 3'h4, ALU_XOR = 3'h5, ALU_FNEG = 3'h6, ALU_FABS = 3'h7
    } sdp_alu_op_t;
    typedef enum logic [2:0] {
        UB_NONE = 3'h0, UB_SET = 3'h1, UB_CLR = 3'h2, UB_TGL = 3'h3,
        UB_TST = 3'h4, UB_XOR = 3'h5
    } sdp_ubit_op_t;
    typedef enum logic [1:0] {
        PX_NONE = 2'h0, PX_FROM_PM = 2'h1, PX_FROM_DM = 2'h2, PX_FROM_RF = 2'h3
    } sdp_px_op_t;
    typedef struct packed {
        logic valid;
        sdp_alu_op_t alu_op;
        logic mul_en;
        logic shf_en;
        logic shf_left;
        logic [3:0] rx;
        logic [3:0] ry;
        logic [3:0] rd_alu;
        logic [3:0] rd_mul;
        logic [3:0] rd_shf;
        logic ld_a_en;
        logic [3:0] ld_a_reg;
        logic ld_b_en;
        logic [3:0] ld_b_reg;
        logic st_en;
        logic [3:0] st_reg;
    } sdp_instr_t;

    // 32-bit words sit in the upper bits of a 40-bit register
    function automatic logic [`SDP_DW-1:0] sdp_fix(input logic [`SDP_WW-1:0] v);
        return {v, {`SDP_FXL{1'b0}}};
    endfunction : sdp_fix
endpackage : sdp_pkg

// ### inc/sdp_pe_if.sv
// link between the core and one processing element
`timescale 1ns/1ps
interface sdp_pe_if;
    import sdp_pkg::*;
    sdp_instr_t instr;
    logic enable;
    logic rf_bank;
    logic mrf_bank;
    logic [`SDP_DW-1:0] ld_a;
    logic [`SDP_DW-1:0] ld_b;
    logic [`SDP_DW-1:0] st_data;
    logic [`SDP_DW-1:0] res;
    logic [`SDP_MW-1:0] mrf;
    modport core (output instr, enable, rf_bank, mrf_bank, ld_a, ld_b,
                  input st_data, res, mrf);
    modport pe (input instr, enable, rf_bank, mrf_bank, ld_a, ld_b,
                output st_data, res, mrf);
endinterface : sdp_pe_if

// ### core/sdp_pe.sv
// one processing element: register file, alu, multiplier, shifter
`timescale 1ns/1ps
module sdp_pe (
    input wire logic core_clk,
    input wire logic resetn,
    sdp_pe_if.pe pif
);
    import sdp_pkg::*;
    logic [`SDP_DW-1:0] rf_q [`SDP_RF_REGS];
    logic [`SDP_DW-1:0] rf_d [`SDP_RF_REGS];
    logic [`SDP_MW-1:0] mrf_q [2];
    logic [`SDP_MW-1:0] mrf_d [2];
    logic [`SDP_DW-1:0] res_q;
    logic [`SDP_DW-1:0] res_d;
    logic [`SDP_DW-1:0] opa;
    logic [`SDP_DW-1:0] opb;
    logic [`SDP_DW-1:0] alu_v;
    logic [`SDP_DW-1:0] shf_v;
    logic [`SDP_MW-1:0] mul_v;
    logic [`SDP_WW-1:0] fa;
    logic [`SDP_WW-1:0] fb;
    sdp_instr_t in;
    logic go;

    function automatic logic [4:0] phys(input logic bank, input logic [3:0] idx);
        return {bank, idx};
    endfunction : phys

    always_comb begin
        in = pif.instr;
        go = in.valid && pif.enable; // RULE_02 RULE_15
        opa = rf_q[phys(pif.rf_bank, in.rx)]; // RULE_08
        opb = rf_q[phys(pif.rf_bank, in.ry)];
        fa = opa[`SDP_FXH:`SDP_FXL];
        fb = opb[`SDP_FXH:`SDP_FXL];
        unique case (in.alu_op) // RULE_07
            ALU_NOP: alu_v = opa;
            ALU_ADD: alu_v = sdp_fix(fa + fb);
            ALU_SUB: alu_v = sdp_fix(fa - fb);
            ALU_AND: alu_v = sdp_fix(fa & fb);
            ALU_OR: alu_v = sdp_fix(fa | fb);
            ALU_XOR: alu_v = sdp_fix(fa ^ fb);
            // float sign ops work on the full 40-bit word, so both precisions fit
            ALU_FNEG: alu_v = {~opa[`SDP_SIGN], opa[`SDP_SIGN-1:0]};
            ALU_FABS: alu_v = {1'b0, opa[`SDP_SIGN-1:0]};
        endcase
        mul_v = $signed(fa) * $signed(fb);
        if (in.shf_left) begin
            shf_v = sdp_fix(fa << opb[`SDP_SHH:`SDP_FXL]);
        end else begin
            shf_v = sdp_fix(fa >> opb[`SDP_SHH:`SDP_FXL]);
        end
        rf_d = rf_q;
        mrf_d = mrf_q;
        res_d = res_q;
        if (go) begin // RULE_05 RULE_06
            if (in.alu_op != ALU_NOP) begin
                rf_d[phys(pif.rf_bank, in.rd_alu)] = alu_v;
                res_d = alu_v;
            end
            if (in.mul_en) begin
                rf_d[phys(pif.rf_bank, in.rd_mul)] = sdp_fix(mul_v[`SDP_WW-1:0]);
                mrf_d[pif.mrf_bank] = mul_v; // RULE_09
            end
            if (in.shf_en) begin
                rf_d[phys(pif.rf_bank, in.rd_shf)] = shf_v;
            end
            // loads win over results aimed at the same register
            if (in.ld_b_en) begin
                rf_d[phys(pif.rf_bank, in.ld_b_reg)] = pif.ld_b;
            end
            if (in.ld_a_en) begin
                rf_d[phys(pif.rf_bank, in.ld_a_reg)] = pif.ld_a;
            end
        end
        pif.st_data = rf_q[phys(pif.rf_bank, in.st_reg)];
        pif.res = res_q;
        pif.mrf = mrf_q[pif.mrf_bank];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `SDP_RF_REGS; i++) begin
                rf_q[i] <= '0;
            end
            mrf_q[0] <= '0;
            mrf_q[1] <= '0;
            res_q <= '0;
        end else begin
            rf_q <= rf_d;
            mrf_q <= mrf_d;
            res_q <= res_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_off_res_hold: assert property (!pif.enable |=> $stable(res_q)) // RULE_15
        else $error("disabled element changed its result");
    a_off_mrf_hold: assert property (!pif.enable |=> $stable(mrf_q[0]) && $stable(mrf_q[1])) // RULE_15
        else $error("disabled element changed its multiplier result");
    a_add_one_cycle: assert property (go && in.alu_op == ALU_ADD // RULE_05
        |=> res_q[`SDP_FXH:`SDP_FXL] == $past(fa) + $past(fb))
        else $error("add result not ready after one cycle");
    a_multifunc_both: assert property (go && in.mul_en && in.alu_op == ALU_SUB // RULE_06
        |=> res_q[`SDP_FXH:`SDP_FXL] == $past(fa) - $past(fb)
            && mrf_q[$past(pif.mrf_bank)] == $past(mul_v))
        else $error("alu and multiplier did not both finish");
    a_fneg_sign: assert property (go && in.alu_op == ALU_FNEG // RULE_07
        |=> res_q[`SDP_SIGN] != $past(opa[`SDP_SIGN]))
        else $error("float negate left the sign alone");
    c_multifunc: cover property (go && in.mul_en && in.alu_op != ALU_NOP && in.shf_en);
endmodule : sdp_pe

// ### core/sdp_core.sv
// dual processing-element datapath with mode, universal, exchange and address registers
`timescale 1ns/1ps
module sdp_core (
    input wire logic core_clk,
    input wire logic resetn,
    input wire sdp_pkg::sdp_instr_t instr,
    input wire logic [`SDP_BW-1:0] dm_rdata,
    input wire logic [`SDP_BW-1:0] pm_rdata,
    input wire logic mode_wr,
    input wire logic [`SDP_WW-1:0] mode_wdata,
    input wire sdp_pkg::sdp_ubit_op_t ubit_op,
    input wire logic [2:0] ubit_tgt,
    input wire logic [`SDP_WW-1:0] ubit_mask,
    input wire sdp_pkg::sdp_px_op_t px_op,
    input wire logic dag_wr,
    input wire logic [3:0] dag_idx,
    input wire logic [`SDP_WW-1:0] dag_wdata,
    output logic [`SDP_WW-1:0] first_mode_ctl,
    output logic [`SDP_WW-1:0] ubit_reg [`SDP_UBR_N],
    output logic ubit_test,
    output logic [`SDP_BW-1:0] px_data,
    output logic [`SDP_BW-1:0] dm_wdata,
    output logic [`SDP_WW-1:0] dag_rdata,
    output logic [`SDP_DW-1:0] x_result,
    output logic [`SDP_DW-1:0] y_result,
    output logic [`SDP_MW-1:0] x_mrf,
    output logic [`SDP_MW-1:0] y_mrf
);
    import sdp_pkg::*;
    logic [`SDP_WW-1:0] first_mode_control_register_q, first_mode_control_register_d;
    logic [`SDP_WW-1:0] ust_q [`SDP_UBR_N];
    logic [`SDP_WW-1:0] ust_d [`SDP_UBR_N];
    logic test_q, test_d;
    logic [`SDP_BW-1:0] px_q, px_d;
    logic [`SDP_BW-1:0] dmw_q, dmw_d;
    logic [`SDP_WW-1:0] dag_q [`SDP_DAG_REGS];
    logic [`SDP_WW-1:0] dag_d [`SDP_DAG_REGS];
    logic [`SDP_WW-1:0] dagr_q, dagr_d;
    logic [`SDP_WW-1:0] tgt_v;
    logic dual;
    sdp_pe_if pif_x ();
    sdp_pe_if pif_y ();

    function automatic logic [`SDP_WW-1:0] ubit_apply(input sdp_ubit_op_t op,
            input logic [`SDP_WW-1:0] v, input logic [`SDP_WW-1:0] m);
        unique case (op)
            UB_SET: return v | m;
            UB_CLR: return v & ~m;
            UB_TGL: return v ^ m;
            UB_NONE, UB_TST, UB_XOR: return v;
            default: return v;
        endcase
    endfunction : ubit_apply

    sdp_pe u_pe_x (
        .core_clk(core_clk),
        .resetn(resetn),
        .pif(pif_x.pe)
    );
    sdp_pe u_pe_y (
        .core_clk(core_clk),
        .resetn(resetn),
        .pif(pif_y.pe)
    );

    // element wiring
    always_comb begin
        dual = first_mode_control_register_q[`SDP_M1_PE2_EN];
        pif_x.instr = instr; // RULE_03
        pif_y.instr = instr;
        pif_x.enable = 1'b1; // RULE_01
        pif_y.enable = dual; // RULE_02
        pif_x.rf_bank = first_mode_control_register_q[`SDP_M1_RF_SEC]; // RULE_10
        pif_y.rf_bank = first_mode_control_register_q[`SDP_M1_RF_SEC];
        pif_x.mrf_bank = first_mode_control_register_q[`SDP_M1_MRF_SEC];
        pif_y.mrf_bank = first_mode_control_register_q[`SDP_M1_MRF_SEC];
        // low word feeds the primary element, high word the second: four words a cycle
        pif_x.ld_a = sdp_fix(dm_rdata[`SDP_WW-1:0]); // RULE_04 RULE_13 RULE_14
        pif_y.ld_a = sdp_fix(dm_rdata[`SDP_BW-1:`SDP_WW]);
        pif_x.ld_b = sdp_fix(pm_rdata[`SDP_WW-1:0]);
        pif_y.ld_b = sdp_fix(pm_rdata[`SDP_BW-1:`SDP_WW]);
    end

    // mode, universal bit and exchange registers
    always_comb begin
        first_mode_control_register_d = first_mode_control_register_q;
        ust_d = ust_q;
        test_d = test_q;
        px_d = px_q;
        tgt_v = (ubit_tgt == `SDP_TGT_FIRST_MODE_CONTROL_REGISTER) ? first_mode_control_register_q : ust_q[ubit_tgt[1:0]];
        if (ubit_op == UB_TST) begin // RULE_11
            test_d = (tgt_v & ubit_mask) == ubit_mask;
        end else if (ubit_op == UB_XOR) begin
            test_d = (tgt_v ^ ubit_mask) == '0;
        end
        if (ubit_tgt == `SDP_TGT_FIRST_MODE_CONTROL_REGISTER) begin
            first_mode_control_register_d = ubit_apply(ubit_op, first_mode_control_register_q, ubit_mask); // RULE_11
        end else if (ubit_tgt < `SDP_TGT_FIRST_MODE_CONTROL_REGISTER) begin
            ust_d[ubit_tgt[1:0]] = ubit_apply(ubit_op, tgt_v, ubit_mask);
        end
        // a direct write outranks a bit operation in the same cycle
        if (mode_wr) begin
            first_mode_control_register_d = mode_wdata;
        end
        unique case (px_op) // RULE_12
            PX_NONE: px_d = px_q;
            PX_FROM_PM: px_d = pm_rdata;
            PX_FROM_DM: px_d = dm_rdata;
            PX_FROM_RF: px_d = {{(`SDP_BW-`SDP_DW){1'b0}}, pif_x.st_data};
        endcase
    end

    // stores and address registers
    always_comb begin
        dmw_d = dmw_q;
        if (instr.valid && instr.st_en) begin
            if (dual) begin // RULE_04
                dmw_d = {pif_y.st_data[`SDP_FXH:`SDP_FXL], pif_x.st_data[`SDP_FXH:`SDP_FXL]};
            end else begin // RULE_15
                dmw_d = {{`SDP_WW{1'b0}}, pif_x.st_data[`SDP_FXH:`SDP_FXL]};
            end
        end
        dag_d = dag_q;
        if (dag_wr) begin
            dag_d[{first_mode_control_register_q[`SDP_M1_DAG_SEC], dag_idx}] = dag_wdata; // RULE_09
        end
        dagr_d = dag_q[{first_mode_control_register_q[`SDP_M1_DAG_SEC], dag_idx}];
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            first_mode_control_register_q <= `SDP_FIRST_MODE_CONTROL_REGISTER_RST; // RULE_10
            for (int i = 0; i < `SDP_UBR_N; i++) begin
                ust_q[i] <= '0;
            end
            for (int i = 0; i < `SDP_DAG_REGS; i++) begin
                dag_q[i] <= '0;
            end
            test_q <= 1'b0;
            px_q <= '0;
            dmw_q <= '0;
            dagr_q <= '0;
        end else begin
            first_mode_control_register_q <= first_mode_control_register_d;
            ust_q <= ust_d;
            dag_q <= dag_d;
            test_q <= test_d;
            px_q <= px_d;
            dmw_q <= dmw_d;
            dagr_q <= dagr_d;
        end
    end

    assign first_mode_ctl = first_mode_control_register_q;
    assign ubit_reg = ust_q;
    assign ubit_test = test_q;
    assign px_data = px_q;
    assign dm_wdata = dmw_q;
    assign dag_rdata = dagr_q;
    assign x_result = pif_x.res;
    assign y_result = pif_y.res;
    assign x_mrf = pif_x.mrf;
    assign y_mrf = pif_y.mrf;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_pe2_follow: assert property (pif_y.enable == first_mode_control_register_q[`SDP_M1_PE2_EN]) // RULE_02
        else $error("second element enable differs from mode bit");
    a_pe1_always: assert property (pif_x.enable) // RULE_01
        else $error("primary element switched off");
    a_dual_store: assert property (instr.valid && instr.st_en && dual // RULE_04
        |=> dm_wdata[`SDP_BW-1:`SDP_WW] == $past(pif_y.st_data[`SDP_FXH:`SDP_FXL]))
        else $error("dual store lost the second value");
    a_single_store: assert property (instr.valid && instr.st_en && !dual // RULE_15
        |=> dm_wdata[`SDP_BW-1:`SDP_WW] == '0)
        else $error("single store carried a second value");
    a_ubit_set: assert property (ubit_op == UB_SET && ubit_tgt == 3'h1 && !mode_wr // RULE_11
        |=> (ust_q[1] & $past(ubit_mask)) == $past(ubit_mask))
        else $error("bit set did not set the mask bits");
    a_px_from_pm: assert property (px_op == PX_FROM_PM |=> px_q == $past(pm_rdata)) // RULE_12
        else $error("exchange register missed program bus load");
    c_dual_store: cover property (dual && instr.valid && instr.st_en);
    c_sec_bank: cover property (first_mode_control_register_q[`SDP_M1_RF_SEC] && instr.valid);
    c_ubit_test: cover property (ubit_op == UB_TST ##1 ubit_test);
endmodule : sdp_core

// ### sim/sdp_bus_model.sv
// memory-bus side model: feeds both read buses of the datapath
`timescale 1ns/1ps
module sdp_bus_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic dm_ld,
    input wire logic pm_ld,
    input wire logic [63:0] dm_word,
    input wire logic [63:0] pm_word,
    output logic [63:0] dm_rdata,
    output logic [63:0] pm_rdata
);
    logic [63:0] idle_q;
    logic [63:0] idle_d;
    // idle buses flip every cycle so a stale word never passes for a load
    always_comb begin
        idle_d = ~idle_q;
    end
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            idle_q <= 64'hA5A5_5A5A_C3C3_3C3C;
        end else begin
            idle_q <= idle_d;
        end
    end
    // two 32-bit words on each bus in one cycle, four in all
    assign dm_rdata = dm_ld ? dm_word : idle_q;
    assign pm_rdata = pm_ld ? pm_word : ~idle_q;
endmodule : sdp_bus_model

// ### sim/simd_dual_processing_elements_bench.sv
// self-checking bench for the dual processing-element datapath
`timescale 1ns/1ps
`include "sdp_defs.svh"
module simd_dual_processing_elements_bench;
    import sdp_pkg::*;
    logic core_clk, resetn, mode_wr, dag_wr, dm_ld, pm_ld, ubit_test;
    logic [31:0] mode_wdata, ubit_mask, dag_wdata, first_mode_ctl, dag_rdata;
    logic [31:0] ubit_reg [4];
    logic [63:0] dm_rdata, pm_rdata, dm_word, pm_word, px_data, dm_wdata, x_mrf, y_mrf;
    logic [39:0] x_result, y_result;
    logic [3:0] dag_idx;
    logic [2:0] ubit_tgt;
    sdp_instr_t instr, ins;
    sdp_ubit_op_t ubit_op;
    sdp_px_op_t px_op;
    int bad_count, compares, cycles;

    sdp_core u_dut (.core_clk(core_clk), .resetn(resetn), .instr(instr),
        .dm_rdata(dm_rdata), .pm_rdata(pm_rdata), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata), .ubit_op(ubit_op), .ubit_tgt(ubit_tgt),
        .ubit_mask(ubit_mask), .px_op(px_op), .dag_wr(dag_wr), .dag_idx(dag_idx),
        .dag_wdata(dag_wdata), .first_mode_ctl(first_mode_ctl), .ubit_reg(ubit_reg),
        .ubit_test(ubit_test), .px_data(px_data), .dm_wdata(dm_wdata),
        .dag_rdata(dag_rdata), .x_result(x_result), .y_result(y_result),
        .x_mrf(x_mrf), .y_mrf(y_mrf));
    sdp_bus_model u_bus (.core_clk(core_clk), .resetn(resetn), .dm_ld(dm_ld),
        .pm_ld(pm_ld), .dm_word(dm_word), .pm_word(pm_word), .dm_rdata(dm_rdata),
        .pm_rdata(pm_rdata));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // the whole run needs well under a hundred cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // wide enough for both element results side by side
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one cycle: drive at the falling edge, release the instruction and all strobes one cycle on
    task automatic step();
        instr = ins;
        @(negedge core_clk);
        instr = '0;
        dm_ld = 1'b0;
        pm_ld = 1'b0;
        mode_wr = 1'b0;
        dag_wr = 1'b0;
        ubit_op = UB_NONE;
        px_op = PX_NONE;
        ins = '0;
        ins.valid = 1'b1;
    endtask : step
    task automatic set_mode(input logic [31:0] v);
        mode_wr = 1'b1;
        mode_wdata = v;
        step();
    endtask : set_mode
    task automatic load(input logic [63:0] dw, input logic [63:0] pw);
        ins.ld_a_en = 1'b1;
        ins.ld_a_reg = 4'h1;
        ins.ld_b_en = 1'b1;
        ins.ld_b_reg = 4'h2;
        dm_word = dw;
        pm_word = pw;
        dm_ld = 1'b1;
        pm_ld = 1'b1;
        step();
    endtask : load
    // alu, multiplier and shifter all in one instruction
    task automatic calc();
        ins.alu_op = ALU_ADD;
        ins.rx = 4'h1;
        ins.ry = 4'h2;
        ins.rd_alu = 4'h3;
        ins.mul_en = 1'b1;
        ins.rd_mul = 4'h4;
        ins.shf_en = 1'b1;
        ins.shf_left = 1'b1;
        ins.rd_shf = 4'h5;
        step();
    endtask : calc
    task automatic store(input logic [3:0] r);
        ins.st_en = 1'b1;
        ins.st_reg = r;
        step();
    endtask : store

    task automatic t_reset();
        check(first_mode_ctl, 64'h0);
        check({x_result, y_result}, 80'h0);
        check(px_data | dm_wdata | x_mrf | y_mrf, 64'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_single();
        load(64'h0000_0007_0000_0005, 64'h0000_000A_0000_0003);
        calc();
        check(x_result, 64'h0000_0800);
        check(x_mrf, 64'h0000_000F);
        check(y_result, 64'h0);
        check(y_mrf, 64'h0);
        store(4'h5);
        check(dm_wdata, 64'h0000_0028);
        $display("test single done");
    endtask : t_single
    task automatic t_dual();
        set_mode(32'h0000_0008);
        check(first_mode_ctl, 64'h0000_0008);
        load(64'h0000_0007_0000_0005, 64'h0000_000A_0000_0003);
        calc();
        check({x_result, y_result}, 80'h00_0000_0800_00_0000_1100);
        check({x_mrf[31:0], y_mrf[31:0]}, 64'h0000_000F_0000_0046);
        store(4'h5);
        check(dm_wdata, 64'h0000_1C00_0000_0028);
        ins.alu_op = ALU_FNEG;
        ins.rx = 4'h1;
        step();
        check({x_result, y_result}, 80'h80_0000_0500_80_0000_0700);
        $display("test dual done");
    endtask : t_dual
    task automatic t_off();
        set_mode(32'h0000_0000);
        load(64'h0000_0063_0000_0001, 64'h0000_0063_0000_0001);
        calc();
        check(x_result, 64'h0000_0200);
        check(y_result, 64'h80_0000_0700);
        store(4'h3);
        check(dm_wdata, 64'h0000_0002);
        set_mode(32'h0000_0008);
        store(4'h3);
        check(dm_wdata, 64'h0000_0011_0000_0002);
        $display("test off done");
    endtask : t_off
    task automatic t_px();
        px_op = PX_FROM_PM;
        pm_ld = 1'b1;
        pm_word = 64'hFEDC_BA98_7654_3210;
        step();
        check(px_data, 64'hFEDC_BA98_7654_3210);
        px_op = PX_FROM_DM;
        dm_ld = 1'b1;
        dm_word = 64'h0123_4567_89AB_CDEF;
        step();
        check(px_data, 64'h0123_4567_89AB_CDEF);
        px_op = PX_FROM_RF;
        ins.st_reg = 4'h3;
        step();
        check(px_data, 64'h0000_0200);
        $display("test exchange done");
    endtask : t_px
    task automatic t_bank();
        set_mode(32'h0000_000C);
        check(x_mrf | y_mrf, 64'h0);
        set_mode(32'h0000_0009);
        store(4'h3);
        check(dm_wdata, 64'h0);
        set_mode(32'h0000_0008);
        store(4'h3);
        check(dm_wdata, 64'h0000_0011_0000_0002);
        dag_wr = 1'b1;
        dag_idx = 4'h2;
        dag_wdata = 32'h1234_5678;
        step();
        set_mode(32'h0000_0002);
        step();
        check(dag_rdata, 64'h0);
        set_mode(32'h0000_0000);
        step();
        check(dag_rdata, 64'h1234_5678);
        $display("test banks done");
    endtask : t_bank
    task automatic t_ubit();
        sdp_ubit_op_t ops [6] = '{UB_SET, UB_CLR, UB_TGL, UB_TST, UB_XOR, UB_TST};
        logic [31:0] msk [6] = '{32'h0000_00F0, 32'h0000_0030, 32'h0000_000F,
            32'h0000_00C0, 32'h0000_00CF, 32'h0000_0030};
        logic [31:0] ev [6] = '{32'h0000_00F0, 32'h0000_00C0, 32'h0000_00CF,
            32'h0000_00CF, 32'h0000_00CF, 32'h0000_00CF};
        logic tv [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int k = 0; k < 6; k++) begin
            ubit_op = ops[k];
            ubit_tgt = 3'h1;
            ubit_mask = msk[k];
            step();
            check({ubit_test, ubit_reg[1]}, {tv[k], ev[k]});
        end
        ubit_op = UB_SET;
        ubit_tgt = 3'h4;
        ubit_mask = 32'h0000_0008;
        step();
        check(first_mode_ctl, 64'h0000_0008);
        $display("test bit ops done");
    endtask : t_ubit

    task automatic report_and_stop();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        {resetn, mode_wr, dag_wr, dm_ld, pm_ld} = '0;
        {mode_wdata, ubit_mask, dag_wdata, dm_word, pm_word, dag_idx, ubit_tgt} = '0;
        ubit_op = UB_NONE;
        px_op = PX_NONE;
        instr = '0;
        ins = '0;
        ins.valid = 1'b1;
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        t_reset();
        t_single();
        t_dual();
        t_off();
        t_px();
        t_bank();
        t_ubit();
        report_and_stop();
    end
endmodule : simd_dual_processing_elements_bench
